// File: rtl/dbgtap_pkg.sv
// Purpose: Shared constants and types of the debug test port block.
// Assumes: One CPU clock domain; test pins are sampled, not clocked on.
// Notes: Instruction codes and the id value are local choices.
package dbgtap_pkg;
	localparam int IR_W = 5;
	localparam int DR_W = 32;
	localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;
	localparam logic [IR_W-1:0] OP_IDCODE = 5'h01;
	localparam logic [IR_W-1:0] OP_IMPCODE = 5'h03;
	localparam logic [IR_W-1:0] OP_BYPASS = 5'h1f;
	localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
	// Arbitrary identification value, names no part
	localparam logic [DR_W-1:0] ID_VALUE = 32'h00000001;
	localparam int IMP_IRQ_SUP_BIT = 24;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [3:0] {
		DBGTAP_TLR = 4'h0,
		DBGTAP_RTI = 4'h1,
		DBGTAP_SEL_DR = 4'h2,
		DBGTAP_CAP_DR = 4'h3,
		DBGTAP_SHF_DR = 4'h4,
		DBGTAP_EX1_DR = 4'h5,
		DBGTAP_PAU_DR = 4'h6,
		DBGTAP_EX2_DR = 4'h7,
		DBGTAP_UPD_DR = 4'h8,
		DBGTAP_SEL_IR = 4'h9,
		DBGTAP_CAP_IR = 4'ha,
		DBGTAP_SHF_IR = 4'hb,
		DBGTAP_EX1_IR = 4'hc,
		DBGTAP_PAU_IR = 4'hd,
		DBGTAP_EX2_IR = 4'he,
		DBGTAP_UPD_IR = 4'hf
	} dbgtap_state_t;

	function automatic dbgtap_state_t dbgtap_next(input dbgtap_state_t s,
		input logic tms);
		case (s)
			DBGTAP_TLR: dbgtap_next = tms ? DBGTAP_TLR : DBGTAP_RTI;
			DBGTAP_RTI: dbgtap_next = tms ? DBGTAP_SEL_DR : DBGTAP_RTI;
			DBGTAP_SEL_DR: dbgtap_next = tms ? DBGTAP_SEL_IR : DBGTAP_CAP_DR;
			DBGTAP_CAP_DR: dbgtap_next = tms ? DBGTAP_EX1_DR : DBGTAP_SHF_DR;
			DBGTAP_SHF_DR: dbgtap_next = tms ? DBGTAP_EX1_DR : DBGTAP_SHF_DR;
			DBGTAP_EX1_DR: dbgtap_next = tms ? DBGTAP_UPD_DR : DBGTAP_PAU_DR;
			DBGTAP_PAU_DR: dbgtap_next = tms ? DBGTAP_EX2_DR : DBGTAP_PAU_DR;
			DBGTAP_EX2_DR: dbgtap_next = tms ? DBGTAP_UPD_DR : DBGTAP_SHF_DR;
			DBGTAP_UPD_DR: dbgtap_next = tms ? DBGTAP_SEL_DR : DBGTAP_RTI;
			DBGTAP_SEL_IR: dbgtap_next = tms ? DBGTAP_TLR : DBGTAP_CAP_IR;
			DBGTAP_CAP_IR: dbgtap_next = tms ? DBGTAP_EX1_IR : DBGTAP_SHF_IR;
			DBGTAP_SHF_IR: dbgtap_next = tms ? DBGTAP_EX1_IR : DBGTAP_SHF_IR;
			DBGTAP_EX1_IR: dbgtap_next = tms ? DBGTAP_UPD_IR : DBGTAP_PAU_IR;
			DBGTAP_PAU_IR: dbgtap_next = tms ? DBGTAP_EX2_IR : DBGTAP_PAU_IR;
			DBGTAP_EX2_IR: dbgtap_next = tms ? DBGTAP_UPD_IR : DBGTAP_SHF_IR;
			default: dbgtap_next = tms ? DBGTAP_SEL_DR : DBGTAP_RTI;
		endcase
	endfunction : dbgtap_next
endpackage : dbgtap_pkg

// File: rtl/dbgtap_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Each bit is a slow level; bits are not coherent as a word.
// Notes: Only the second stage leaves this module.
module dbgtap_sync import dbgtap_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = reset_n_in ? async_in : INIT;
		next_sync = reset_n_in ? meta : INIT;
	end

	always_ff @(posedge ref_clk_in) begin
		meta <= next_meta;
		sync_out <= next_sync;
	end
endmodule : dbgtap_sync

// File: rtl/dbgtap_top.sv
// Purpose: Test access port pins, debug interrupt capture, debug-mode
//   and coprocessor idle sideband of a processor core.
// Assumes: Test clock is far slower than ref_clk_in and is sampled.
// Notes: Data-out changes on the sampled falling test clock edge.
// Contract
// - Coprocessor idle is ignored unless the present strap is high.
// - Without the port controller, test pins stay unconnected.
// - Active-low test reset resets the port controller; asserted at power-up.
// - Port logic advances only on the dedicated test clock.
// - Float indication is 1 when data-out floats, 0 when driven.
// - Data-out floats outside shift states as boundary scan requires.
// - Interrupt support strap appears in the implementation register.
// - Debug request is taken only on a low-to-high interrupt edge.
// - Entering debug mode clears pending request; requests there dropped.
// - Debug-mode output stands high while the core is in debug mode.
module dbgtap_top import dbgtap_pkg::*; #(
	parameter bit TAP_PRESENT = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic dbg_test_reset_n_in,
	input wire logic dbg_test_clock_in,
	input wire logic dbg_test_mode_select_in,
	input wire logic dbg_test_data_in_in,
	input wire logic dbg_irq_request_in,
	input wire logic dbg_irq_supported_in,
	input wire logic coproc_idle_in,
	input wire logic coproc_present_in,
	input wire logic debug_mode_in,
	output logic dbg_test_data_out_out,
	output logic dbg_data_out_float_out,
	output logic dbg_irq_out,
	output logic in_debug_mode_out,
	output logic coproc_idle_out
);
	logic [7:0] pins_s;
	logic tck_s, trst_n_s, tms_s, tdi_s, irq_s, sup_s, cidle_s, cpres_s;
	logic tck_q, irq_q;
	logic tck_rise, tck_fall;
	dbgtap_state_t tap_state, next_tap_state;
	logic [IR_W-1:0] ir, next_ir, ir_sh, next_ir_sh;
	logic [DR_W-1:0] dr_sh, next_dr_sh;
	logic next_tdo, next_float;
	logic next_irq, next_dbgm, next_cidle;

	// Straps pass the synchroniser too; they are static after reset
	dbgtap_sync #(.WIDTH(8), .INIT(8'h02)) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({coproc_present_in, coproc_idle_in, dbg_irq_supported_in,
			dbg_irq_request_in, dbg_test_data_in_in,
			dbg_test_mode_select_in, dbg_test_reset_n_in, dbg_test_clock_in}),
		.sync_out(pins_s)
	);
	assign {cpres_s, cidle_s, sup_s, irq_s, tdi_s, tms_s, trst_n_s, tck_s} =
		pins_s;

	assign tck_rise = tck_s & ~tck_q;
	assign tck_fall = ~tck_s & tck_q;

	function automatic logic shifting(input dbgtap_state_t s);
		shifting = (s == DBGTAP_SHF_DR) || (s == DBGTAP_SHF_IR);
	endfunction : shifting

	always_comb begin
		next_tap_state = tap_state;
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_dr_sh = dr_sh;
		next_tdo = dbg_test_data_out_out;
		next_float = dbg_data_out_float_out;
		if (!TAP_PRESENT) begin
			next_tap_state = DBGTAP_TLR;
			next_tdo = 1'b0;
			next_float = 1'b1;
		end else if (!trst_n_s) begin
			next_tap_state = DBGTAP_TLR;
			next_ir = IR_RESET;
			next_tdo = 1'b0;
			next_float = 1'b1;
		end else if (tck_rise) begin
			next_tap_state = dbgtap_next(tap_state, tms_s);
			case (tap_state)
				DBGTAP_TLR: next_ir = IR_RESET;
				DBGTAP_CAP_IR: next_ir_sh = IR_CAPTURE;
				DBGTAP_SHF_IR: next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
				DBGTAP_UPD_IR: next_ir = ir_sh;
				DBGTAP_CAP_DR: begin
					next_dr_sh = '0;
					if (ir == OP_IDCODE) begin
						next_dr_sh = ID_VALUE;
					end else if (ir == OP_IMPCODE) begin
						next_dr_sh[IMP_IRQ_SUP_BIT] = sup_s;
					end
				end
				DBGTAP_SHF_DR: begin
					if (ir == OP_IDCODE || ir == OP_IMPCODE) begin
						next_dr_sh = {tdi_s, dr_sh[DR_W-1:1]};
					end else begin
						// Bypass and unknown codes use a single bit
						next_dr_sh = {{(DR_W-1){1'b0}}, tdi_s};
					end
				end
				default: ;
			endcase
		end else if (tck_fall) begin
			// float high unless shifting; falling-edge update
			next_float = !shifting(tap_state);
			next_tdo = (tap_state == DBGTAP_SHF_IR) ? ir_sh[0] : dr_sh[0];
		end
	end

	always_comb begin
		next_dbgm = debug_mode_in;
		next_irq = dbg_irq_out;
		if (irq_s && !irq_q) begin
			next_irq = 1'b1;
		end
		// entry clears, requests in debug mode dropped
		if (debug_mode_in) begin
			next_irq = 1'b0;
		end
		// idle only counts with coprocessor present
		next_cidle = cidle_s & cpres_s;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			tck_q <= 1'b0;
			irq_q <= 1'b0;
			tap_state <= DBGTAP_TLR;
			ir <= IR_RESET;
			ir_sh <= '0;
			dr_sh <= '0;
			dbg_test_data_out_out <= 1'b0;
			dbg_data_out_float_out <= 1'b1;
			dbg_irq_out <= 1'b0;
			in_debug_mode_out <= 1'b0;
			coproc_idle_out <= 1'b0;
		end else begin
			tck_q <= tck_s;
			irq_q <= irq_s;
			tap_state <= next_tap_state;
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			dr_sh <= next_dr_sh;
			dbg_test_data_out_out <= next_tdo;
			dbg_data_out_float_out <= next_float;
			dbg_irq_out <= next_irq;
			in_debug_mode_out <= next_dbgm;
			coproc_idle_out <= next_cidle;
		end
	end

	property p_trst;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		!trst_n_s |=> tap_state == DBGTAP_TLR && dbg_data_out_float_out;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset ignored");

	property p_tck_hold;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(trst_n_s && !tck_rise) |=> $stable(tap_state);
	endproperty
	a_tck_hold: assert property (p_tck_hold) else $error("step w/o tck");

	property p_tlr_stay;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(trst_n_s && tap_state == DBGTAP_TLR && tck_rise && tms_s)
			|=> tap_state == DBGTAP_TLR;
	endproperty
	a_tlr_stay: assert property (p_tlr_stay) else $error("left reset");

	property p_float;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(trst_n_s && tck_fall) |=>
			dbg_data_out_float_out == !shifting($past(tap_state));
	endproperty
	a_float: assert property (p_float) else $error("float wrong");

	property p_float_idle;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(tap_state == DBGTAP_RTI && !tck_rise) |=> dbg_data_out_float_out
			|| !$past(tck_fall, 2);
	endproperty
	a_float_idle: assert property (p_float_idle) else $error("float idle");

	property p_impl;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(trst_n_s && tck_rise && tap_state == DBGTAP_CAP_DR
			&& ir == OP_IMPCODE) |=> dr_sh[IMP_IRQ_SUP_BIT] == $past(sup_s);
	endproperty
	a_impl: assert property (p_impl) else $error("support bit lost");

	property p_irq_edge;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(irq_s && !irq_q && !debug_mode_in) |=> dbg_irq_out;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("edge missed");

	property p_irq_level;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		(!dbg_irq_out && !(irq_s && !irq_q)) |=> !dbg_irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("no edge");

	property p_irq_drop;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		debug_mode_in |=> !dbg_irq_out && in_debug_mode_out;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("kept in debug");

	property p_coproc;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		!cpres_s |=> !coproc_idle_out;
	endproperty
	a_coproc: assert property (p_coproc) else $error("idle w/o present");

	c_irq: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		!dbg_irq_out ##1 dbg_irq_out);
	c_shift_dr: cover property (@(posedge ref_clk_in)
		disable iff (!reset_n_in) tap_state == DBGTAP_SHF_DR
		&& !dbg_data_out_float_out);
	c_upd_ir: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		tap_state == DBGTAP_UPD_IR ##1 tap_state == DBGTAP_RTI);
endmodule : dbgtap_top

// File: tb/dbgtap_probe.sv
// Purpose: Probe model that drives the test port pins.
// Assumes: Test clock idles low and stands still between frames.
// Notes: Data out is sampled just before each rising test clock.
module dbgtap_probe (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	input wire logic tdo_in,
	input wire logic float_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic float_seen;
	logic tdo_pin;
	// board buffer; a floating line shows the inverse
	assign tdo_pin = float_in ? ~tdo_in : tdo_in;
	// probe owns reset, mode and data
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		trst_n_out = 1'b0;
		float_seen = 1'b0;
	end
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#32 tdo = tdo_pin;
		float_seen = float_seen | float_in;
		tck_out = 1'b1;
		#32 tck_out = 1'b0;
		// Unused data line keeps moving
		tdi_out = ~tdi;
	endtask : step
	task automatic walk(input logic [7:0] seq, input int n);
		logic d;
		for (int i = 0; i < n; i++) begin
			step(seq[i], 1'b0, d);
		end
	endtask : walk
	// last bit leaves shift, then update and idle
	task automatic shift(input int n, input logic [31:0] din,
		output logic [31:0] dout, output logic flt);
		logic b;
		dout = 32'h0;
		float_seen = 1'b0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
		flt = float_seen;
		walk(8'h01, 2);
	endtask : shift
	task automatic test_reset();
		trst_n_out = 1'b0;
		#100 trst_n_out = 1'b1;
		#100;
	endtask : test_reset
endmodule : dbgtap_probe

// File: tb/tb.sv
// Purpose: Self-checking bench of the debug test port block.
// Assumes: Probe model paces the test clock at 64 ns.
// Notes: Bench inputs change on the falling ref clock.
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
	miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
	end end
module tb import dbgtap_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset_n = 1'b0, irq_pin = 1'b0, irq_sup = 1'b0;
	logic cp_idle = 1'b0, cp_present = 1'b0, debug_mode = 1'b0;
	logic tck, tms, tdi, trst_n, tdo, flt, irq_o, in_dbg, cp_idle_o;
	int miscompares = 0;
	int n_checks = 0;
	dbgtap_probe probe (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.trst_n_out(trst_n), .tdo_in(tdo), .float_in(flt));
	dbgtap_top dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n),
		.dbg_test_reset_n_in(trst_n), .dbg_test_clock_in(tck),
		.dbg_test_mode_select_in(tms), .dbg_test_data_in_in(tdi),
		.dbg_irq_request_in(irq_pin), .dbg_irq_supported_in(irq_sup),
		.coproc_idle_in(cp_idle), .coproc_present_in(cp_present),
		.debug_mode_in(debug_mode), .dbg_test_data_out_out(tdo),
		.dbg_data_out_float_out(flt), .dbg_irq_out(irq_o),
		.in_debug_mode_out(in_dbg), .coproc_idle_out(cp_idle_o));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic t_coproc();
		// idle only while idle; strap tied once attached
		cp_idle = 1'b1;
		cyc(5);
		`CHK("cp gated", 1'b0, cp_idle_o)
		cp_present = 1'b1;
		cyc(5);
		`CHK("cp idle", 1'b1, cp_idle_o)
		cp_idle = 1'b0;
		cyc(5);
		`CHK("cp busy", 1'b0, cp_idle_o)
	endtask : t_coproc
	task automatic t_irq();
		irq_pin = 1'b1;
		cyc(4);
		`CHK("irq rise", 1'b1, irq_o)
		cyc(6);
		`CHK("irq held", 1'b1, irq_o)
		debug_mode = 1'b1;
		// one-cycle copy lets cores line up
		cyc(1);
		`CHK("debug sync", 1'b1, in_dbg)
		cyc(1);
		`CHK("irq cleared", 1'b0, irq_o)
		`CHK("debug on", 1'b1, in_dbg)
		irq_pin = 1'b0;
		cyc(4);
		irq_pin = 1'b1;
		cyc(5);
		`CHK("irq in debug", 1'b0, irq_o)
		debug_mode = 1'b0;
		cyc(5);
		`CHK("irq level", 1'b0, irq_o)
		`CHK("debug off", 1'b0, in_dbg)
		irq_pin = 1'b0;
		cyc(4);
		irq_pin = 1'b1;
		cyc(4);
		`CHK("irq again", 1'b1, irq_o)
	endtask : t_irq
	// From reset state straight into a data shift
	task automatic t_id(output logic [31:0] d);
		logic f;
		probe.walk(8'h02, 4);
		probe.shift(32, 32'hffffffff, d, f);
		`CHK("float in shift", 1'b0, f)
		cyc(4);
		`CHK("float idle", 1'b1, flt)
	endtask : t_id
	task automatic t_imp();
		logic [31:0] d;
		logic f;
		for (int s = 0; s < 2; s++) begin
			irq_sup = s[0];
			cyc(4);
			probe.walk(8'h03, 4);
			probe.shift(5, {27'h0, OP_IMPCODE}, d, f);
			`CHK("ir capture", IR_CAPTURE, d[4:0])
			probe.walk(8'h01, 3);
			probe.shift(32, 32'h0, d, f);
			`CHK("imp", 32'(s) << IMP_IRQ_SUP_BIT, d)
		end
	endtask : t_imp
	task automatic t_bypass();
		logic [31:0] d;
		logic f;
		probe.walk(8'h03, 4);
		probe.shift(5, {27'h0, OP_BYPASS}, d, f);
		probe.walk(8'h01, 3);
		probe.shift(32, 32'h80000005, d, f);
		`CHK("bypass float", 1'b0, f)
		`CHK("bypass", 32'h0000000a, d)
	endtask : t_bypass
	// Five mode-select highs reach the reset state from anywhere
	task automatic t_tms_reset();
		logic [31:0] d;
		probe.walk(8'h1f, 5);
		t_id(d);
		`CHK("id after tms reset", ID_VALUE, d)
	endtask : t_tms_reset
	initial begin
		#50us;
		miscompares++;
		wrap_up();
	end
	initial begin
		logic [31:0] d;
		cyc(11);
		`CHK("reset float", 1'b1, flt)
		`CHK("reset irq", 1'b0, irq_o)
		cyc(1);
		reset_n = 1'b1;
		t_coproc();
		t_irq();
		probe.test_reset();
		t_id(d);
		`CHK("idcode", ID_VALUE, d)
		t_imp();
		probe.test_reset();
		t_id(d);
		`CHK("id after trst", ID_VALUE, d)
		t_bypass();
		t_tms_reset();
		wrap_up();
	end
endmodule : tb
